// ### core/rsc_pkg.sv
package rsc_pkg;

    // timing
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned RESTART_WAIT_US = 400;
    localparam int unsigned RESTART_WAIT_CYC = RESTART_WAIT_US * CLK_MHZ;

    // register offsets
    localparam logic [7:0] OFS_SETPOINT = 8'h00;
    localparam logic [7:0] OFS_CFG_A = 8'h01;
    localparam logic [7:0] OFS_CFG_B = 8'h02;
    localparam logic [7:0] OFS_CFG_C = 8'h03;
    localparam logic [7:0] OFS_FLAGS = 8'h04;

    // config_reg_a field positions
    localparam int unsigned CFGA_RESET_BIT = 7;
    localparam int unsigned CFGA_SPREAD_BIT = 6;
    localparam int unsigned CFGA_SWITCHING_ENABLE_BIT_BIT = 5;
    localparam int unsigned CFGA_FORCE_BIT = 4;
    localparam int unsigned CFGA_DRAIN_BIT = 3;
    localparam int unsigned CFGA_RETRY_BIT = 2;
    localparam int unsigned CFGA_SLEW_LSB = 0;
    // config_reg_b range field position
    localparam int unsigned CFGB_RANGE_LSB = 2;

    // reset values; spread default differs by variant
    localparam logic SPREAD_DEFAULT = 1'b0;
    localparam logic [6:0] CFGA_RESET = {SPREAD_DEFAULT, 6'h28};
    localparam logic [7:0] CFGB_RESET = 8'h0a;
    localparam logic [7:0] CFGC_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;

    // setpoint defaults selected by the startup pin level
    localparam logic [7:0] STARTUP_CODE_0 = 8'h50;
    localparam logic [7:0] STARTUP_CODE_1 = 8'h64;
    localparam logic [7:0] STARTUP_CODE_2 = 8'h78;
    localparam logic [7:0] STARTUP_CODE_3 = 8'ha0;

    // voltage arithmetic in microvolts
    localparam logic [20:0] BASE_UV = 21'd400000;
    localparam logic [20:0] STEP_UV_R1 = 21'd1250;
    localparam logic [20:0] STEP_UV_R2 = 21'd2500;
    localparam logic [20:0] STEP_UV_R3 = 21'd5000;

    // slew rates in uV/us for codes 00..11
    localparam int unsigned RATE_UV_US_0 = 10000;
    localparam int unsigned RATE_UV_US_1 = 5000;
    localparam int unsigned RATE_UV_US_2 = 1250;
    localparam int unsigned RATE_UV_US_3 = 500;
    // cycles per code in the finest range; coarser ranges shift left
    localparam logic [11:0] RAMP_CYC_0 = 12'(1250 * CLK_MHZ / RATE_UV_US_0);
    localparam logic [11:0] RAMP_CYC_1 = 12'(1250 * CLK_MHZ / RATE_UV_US_1);
    localparam logic [11:0] RAMP_CYC_2 = 12'(1250 * CLK_MHZ / RATE_UV_US_2);
    localparam logic [11:0] RAMP_CYC_3 = 12'(1250 * CLK_MHZ / RATE_UV_US_3);

    // serial target address, arbitrary value
    localparam logic [6:0] TARGET_ADDR = 7'h42;

    typedef enum logic [3:0] {
        I_IDLE  = 4'h0,
        I_ADDR  = 4'h1,
        I_ACK_A = 4'h2,
        I_REG   = 4'h3,
        I_ACK_R = 4'h4,
        I_WDATA = 4'h5,
        I_ACK_W = 4'h6,
        I_RDATA = 4'h7,
        I_RACK  = 4'h8
    } rsc_i2c_e;

    typedef struct packed {
        logic [1:0] startup_sel;
        logic mode_sync;
        logic supply_ok;
        logic scl;
        logic sda;
        logic [5:0] events;
    } rsc_pins_t;

    typedef struct packed {
        rsc_i2c_e ist;
        logic [3:0] bcnt;
        logic [7:0] sh;
        logic rw;
        logic nack;
        logic [7:0] ptr;
        logic sda_drv;
        logic scl_p;
        logic sda_p;
        logic run;
        logic [15:0] wait_cnt;
        logic [7:0] target;
        logic [7:0] eff;
        logic [11:0] rcnt;
        logic [6:0] cfg_a;
        logic [7:0] cfg_b;
        logic [7:0] cfg_c;
        logic [7:0] flags;
        logic [20:0] uv;
        logic pwm;
    } rsc_state_t;

    localparam rsc_state_t STATE_RESET = '{
        ist: I_IDLE,
        cfg_a: CFGA_RESET,
        cfg_b: CFGB_RESET,
        cfg_c: CFGC_RESET,
        flags: FLAGS_RESET,
        default: '0
    };

endpackage

// ### core/rsc_sync.sv
`timescale 1ns/1ns
module rsc_sync #(
    parameter int unsigned WIDTH = 1
) (
    input wire logic mclk, // system clock
    input wire logic sys_rst, // async reset, high
    input wire logic [WIDTH-1:0] din, // asynchronous levels
    output logic [WIDTH-1:0] dout // synchronised levels
);
    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
    } rsc_sync_st_t;

    rsc_sync_st_t q;
    rsc_sync_st_t d;

    always_comb begin
        d.s1 = din;
        d.s2 = q.s1;
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign dout = q.s2;
endmodule

// ### core/rsc_regs.sv
`timescale 1ns/1ns
// Overview of operation
// - all registers return to defaults while supply is below about 1.4V.
// - writing reset bit restarts device, resamples pins, restores defaults; reads as 0.
// - startup setpoint and its reset value come from startup pin sampled at power-up.
// - new setpoint is approached at the selected slew rate, not stepped.
// - target voltage is 0.4V plus code times range step 1.25, 2.5 or 5 mV.
// - bit 6 enables spread-spectrum switching; default depends on variant.
// - bit 5 enables switching, resets to 1; clearing stops switching, keeps registers.
// - bit 4 forces PWM, ORed with the mode/sync pin.
// - bit 3 enables output discharge, resets to 1.
// - bit 2 enables hiccup fault handling, resets to 0; not for stacked use.
// - bits 1-0 pick slew 10, 5, 1.25 or 0.5 mV/us, reset 00b.
// - range field 00b 1.25mV, 01b 2.5mV, 10b/11b 5mV steps.
// - a written value takes effect at the falling edge ending its acknowledge.
// - reads of undefined addresses return zero.
module rsc_regs #(
    parameter int unsigned RESTART_CYC = rsc_pkg::RESTART_WAIT_CYC
) (
    input wire logic mclk, // system clock, 100 MHz
    input wire logic sys_rst, // async reset, active high
    input wire logic scl_i, // serial clock pin
    input wire logic sda_i, // serial data pin level
    output logic sda_o, // serial data drive value, always low
    output logic sda_oe, // serial data pull-low enable
    input wire logic [1:0] startup_select_pin, // startup voltage select level
    input wire logic mode_sync_pin, // mode/sync pin
    input wire logic supply_ok, // supply above retention level
    input wire logic [5:0] event_in, // hiccup, ilim, twarn, tshut, pbuv, pbov
    output logic [7:0] setpoint_code, // effective (ramped) code
    output logic [20:0] vout_target_uv, // effective target in uV
    output logic [1:0] range_select, // active range field
    output logic spread_clock_enable, // spread spectrum on
    output logic switching_active, // converter allowed to switch
    output logic fixed_freq_force, // forced PWM operation
    output logic output_drain_enable, // active discharge on
    output logic fault_retry_enable, // hiccup mode on
    output logic setpoint_slewing, // ramp in progress
    output logic restart_busy // startup wait, writes ignored
);
    rsc_pkg::rsc_state_t q;
    rsc_pkg::rsc_state_t d;
    rsc_pkg::rsc_pins_t pin;
    logic scl;
    logic sda;
    logic rise;
    logic fall;
    logic start;
    logic stop;
    logic flag_clr;
    logic soft_rst;
    logic [11:0] interval;
    logic [20:0] step_uv;
    logic [1:0] rng;

    // every pin is foreign to mclk
    rsc_sync #(
        .WIDTH($bits(rsc_pkg::rsc_pins_t))
    ) u_sync (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din({startup_select_pin, mode_sync_pin, supply_ok, scl_i, sda_i, event_in}),
        .dout(pin)
    );

    function automatic logic [7:0] read_reg(input logic [7:0] a, input rsc_pkg::rsc_state_t s);
        logic [7:0] r;
        case (a)
            rsc_pkg::OFS_SETPOINT: r = s.target;
            rsc_pkg::OFS_CFG_A: r = {1'b0, s.cfg_a};
            rsc_pkg::OFS_CFG_B: r = s.cfg_b;
            rsc_pkg::OFS_CFG_C: r = s.cfg_c;
            rsc_pkg::OFS_FLAGS: r = s.flags;
            default: r = 8'h00;
        endcase
        return r;
    endfunction

    function automatic logic [7:0] startup_code(input logic [1:0] sel);
        logic [7:0] c;
        case (sel)
            2'h0: c = rsc_pkg::STARTUP_CODE_0;
            2'h1: c = rsc_pkg::STARTUP_CODE_1;
            2'h2: c = rsc_pkg::STARTUP_CODE_2;
            default: c = rsc_pkg::STARTUP_CODE_3;
        endcase
        return c;
    endfunction

    always_comb begin
        d = q;
        flag_clr = 1'b0;
        soft_rst = 1'b0;
        scl = pin.scl;
        sda = pin.sda;
        rise = scl & ~q.scl_p;
        fall = ~scl & q.scl_p;
        start = scl & q.scl_p & q.sda_p & ~sda;
        stop = scl & q.scl_p & ~q.sda_p & sda;
        d.scl_p = scl;
        d.sda_p = sda;
        rng = q.cfg_b[rsc_pkg::CFGB_RANGE_LSB +: 2];

        // serial target
        if (stop) begin
            d.ist = rsc_pkg::I_IDLE;
            d.sda_drv = 1'b0;
        end else if (start) begin
            d.ist = rsc_pkg::I_ADDR;
            d.bcnt = 4'h0;
            d.sda_drv = 1'b0;
        end else begin
            case (q.ist)
                rsc_pkg::I_ADDR, rsc_pkg::I_REG, rsc_pkg::I_WDATA: begin
                    if (rise) begin
                        d.sh = {q.sh[6:0], sda};
                        d.bcnt = q.bcnt + 4'h1;
                    end else if (fall && q.bcnt == 4'h8) begin
                        d.bcnt = 4'h0;
                        d.sda_drv = 1'b1;
                        case (q.ist)
                            rsc_pkg::I_ADDR: begin
                                d.rw = q.sh[0];
                                if (q.sh[7:1] == rsc_pkg::TARGET_ADDR) begin
                                    d.ist = rsc_pkg::I_ACK_A;
                                end else begin
                                    d.sda_drv = 1'b0;
                                    d.ist = rsc_pkg::I_IDLE;
                                end
                            end
                            rsc_pkg::I_REG: begin
                                d.ptr = q.sh;
                                d.ist = rsc_pkg::I_ACK_R;
                            end
                            default: d.ist = rsc_pkg::I_ACK_W;
                        endcase
                    end
                end
                rsc_pkg::I_ACK_A, rsc_pkg::I_ACK_R, rsc_pkg::I_ACK_W, rsc_pkg::I_RACK: begin
                    if (rise && q.ist == rsc_pkg::I_RACK) begin
                        d.nack = sda;
                    end else if (fall) begin
                        d.sda_drv = 1'b0;
                        d.bcnt = 4'h0;
                        if ((q.ist == rsc_pkg::I_ACK_A && q.rw) || (q.ist == rsc_pkg::I_RACK && !q.nack)) begin
                            // load next read byte, pointer auto-increments
                            d.sh = read_reg(q.ptr, q);
                            d.sda_drv = ~d.sh[7];
                            d.ptr = q.ptr + 8'h01;
                            flag_clr = (q.ptr == rsc_pkg::OFS_FLAGS);
                            d.ist = rsc_pkg::I_RDATA;
                        end else if (q.ist == rsc_pkg::I_RACK) begin
                            d.ist = rsc_pkg::I_IDLE;
                        end else if (q.ist == rsc_pkg::I_ACK_A) begin
                            d.ist = rsc_pkg::I_REG;
                        end else begin
                            d.ist = rsc_pkg::I_WDATA;
                        end
                        if (q.ist == rsc_pkg::I_ACK_W) begin
                            d.ptr = q.ptr + 8'h01;
                            // writes land on the ack's falling edge; ignored during startup wait
                            if (q.run) begin
                                case (q.ptr)
                                    rsc_pkg::OFS_SETPOINT: d.target = q.sh;
                                    rsc_pkg::OFS_CFG_A: begin
                                        d.cfg_a = q.sh[6:0];
                                        soft_rst = q.sh[rsc_pkg::CFGA_RESET_BIT];
                                    end
                                    rsc_pkg::OFS_CFG_B: d.cfg_b = q.sh;
                                    rsc_pkg::OFS_CFG_C: d.cfg_c = q.sh;
                                    default: d.ptr = q.ptr + 8'h01;
                                endcase
                            end
                        end
                    end
                end
                rsc_pkg::I_RDATA: begin
                    if (rise) begin
                        d.bcnt = q.bcnt + 4'h1;
                    end else if (fall) begin
                        if (q.bcnt == 4'h8) begin
                            d.sda_drv = 1'b0;
                            d.ist = rsc_pkg::I_RACK;
                        end else begin
                            d.sh = {q.sh[6:0], 1'b0};
                            d.sda_drv = ~q.sh[6];
                        end
                    end
                end
                rsc_pkg::I_IDLE: d.sda_drv = 1'b0;
                default: begin
                    d.ist = rsc_pkg::I_IDLE;
                    d.sda_drv = 1'b0;
                end
            endcase
        end

        // sticky events, clear on read; a coincident event survives the clear
        d.flags = (flag_clr ? 8'h00 : q.flags) | {2'h0, pin.events};

        // startup wait, then pin sample sets the setpoint default
        if (!q.run) begin
            d.wait_cnt = q.wait_cnt + 16'h0001;
            if (q.wait_cnt >= 16'(RESTART_CYC - 1)) begin
                d.run = 1'b1;
                d.target = startup_code(pin.startup_sel);
                d.eff = startup_code(pin.startup_sel);
            end
        end

        // ramp one code per interval; coarser range means longer interval per code
        case (q.cfg_a[rsc_pkg::CFGA_SLEW_LSB +: 2])
            2'h0: interval = rsc_pkg::RAMP_CYC_0;
            2'h1: interval = rsc_pkg::RAMP_CYC_1;
            2'h2: interval = rsc_pkg::RAMP_CYC_2;
            default: interval = rsc_pkg::RAMP_CYC_3;
        endcase
        case (rng)
            2'h0: step_uv = rsc_pkg::STEP_UV_R1;
            2'h1: begin
                step_uv = rsc_pkg::STEP_UV_R2;
                interval = {interval[10:0], 1'b0};
            end
            default: begin
                step_uv = rsc_pkg::STEP_UV_R3;
                interval = {interval[9:0], 2'b00};
            end
        endcase
        if (q.run && q.eff != q.target) begin
            if (q.rcnt >= interval - 12'h001) begin
                d.rcnt = 12'h000;
                d.eff = (q.eff < q.target) ? q.eff + 8'h01 : q.eff - 8'h01;
            end else begin
                d.rcnt = q.rcnt + 12'h001;
            end
        end else begin
            d.rcnt = 12'h000;
        end
        d.uv = rsc_pkg::BASE_UV + 21'(q.eff) * step_uv;
        d.pwm = q.cfg_a[rsc_pkg::CFGA_FORCE_BIT] | pin.mode_sync;

        // software reset and supply loss both restore defaults and restart
        if (soft_rst || !pin.supply_ok) begin
            d = rsc_pkg::STATE_RESET;
            d.scl_p = scl;
            d.sda_p = sda;
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            q <= rsc_pkg::STATE_RESET;
        end else begin
            q <= d;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe = q.sda_drv;
    assign setpoint_code = q.eff;
    assign vout_target_uv = q.uv;
    assign range_select = q.cfg_b[rsc_pkg::CFGB_RANGE_LSB +: 2];
    assign spread_clock_enable = q.cfg_a[rsc_pkg::CFGA_SPREAD_BIT];
    // clearing the enable stops switching only; registers stay
    assign switching_active = q.run & q.cfg_a[rsc_pkg::CFGA_SWITCHING_ENABLE_BIT_BIT];
    assign fixed_freq_force = q.pwm;
    assign output_drain_enable = q.cfg_a[rsc_pkg::CFGA_DRAIN_BIT];
    assign fault_retry_enable = q.cfg_a[rsc_pkg::CFGA_RETRY_BIT];
    assign setpoint_slewing = q.run & (q.eff != q.target);
    assign restart_busy = ~q.run;
endmodule

// ### verification/rsc_ctrl_model.sv
`timescale 1ns/1ns
module rsc_ctrl_model (
    input wire logic mclk, // system clock
    input wire logic sda_w, // resolved data wire
    output logic scl, // serial clock level
    output logic sda_low // pulls the data wire low
);
    int misses = 0;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // low phase 8, high phase 8, sampled mid-high
    task automatic slot(input logic b, output logic r);
        tick(4);
        sda_low = ~b;
        tick(4);
        scl = 1'b1;
        tick(4);
        r = sda_w;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic start_cond();
        tick(4);
        sda_low = 1'b0;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask
    task automatic stop_cond();
        tick(4);
        sda_low = 1'b1;
        tick(4);
        scl = 1'b1;
        tick(4);
        sda_low = 1'b0;
        tick(4);
    endtask
    task automatic send(input logic [7:0] v);
        logic r;
        for (int i = 7; i >= 0; i--) slot(v[i], r);
        slot(1'b1, r);
        if (r !== 1'b0) misses++;
    endtask
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        start_cond();
        send({rsc_pkg::TARGET_ADDR, 1'b0});
        send(a);
        send(d);
        stop_cond();
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        logic r;
        start_cond();
        send({rsc_pkg::TARGET_ADDR, 1'b0});
        send(a);
        start_cond();
        send({rsc_pkg::TARGET_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) begin
            slot(1'b1, r);
            d[i] = r;
        end
        // nack ends the read
        slot(1'b1, r);
        stop_cond();
    endtask
endmodule

// ### verification/rsc_regs_asserts.sv
`timescale 1ns/1ns
module rsc_regs_asserts #(
    parameter int unsigned RESTART_CYC = rsc_pkg::RESTART_WAIT_CYC
) (
    input wire logic mclk, // clock
    input wire logic sys_rst, // reset
    input wire logic mode_sync_pin, // mode pin
    input wire logic supply_ok, // supply good
    input wire logic [1:0] startup_select_pin, // startup level
    input wire logic [7:0] setpoint_code, // ramped code
    input wire logic [20:0] vout_target_uv, // target uV
    input wire logic [1:0] range_select, // range
    input wire logic switching_active, // switching
    input wire logic fixed_freq_force, // forced pwm
    input wire logic setpoint_slewing, // ramping
    input wire logic restart_busy // startup wait
);
    logic [31:0] busy_q;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // supply low time left out: the wait only counts once supply is back
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_q <= '0;
        end else begin
            busy_q <= (restart_busy && supply_ok) ? busy_q + 32'h1 : 32'h0;
        end
    end
    function automatic logic [20:0] step_of(input logic [1:0] r);
        return (r == 2'h0) ? rsc_pkg::STEP_UV_R1 : (r == 2'h1) ? rsc_pkg::STEP_UV_R2 : rsc_pkg::STEP_UV_R3;
    endfunction
    function automatic logic [7:0] code_of(input logic [1:0] p);
        return p[1] ? (p[0] ? rsc_pkg::STARTUP_CODE_3 : rsc_pkg::STARTUP_CODE_2)
                    : (p[0] ? rsc_pkg::STARTUP_CODE_1 : rsc_pkg::STARTUP_CODE_0);
    endfunction
    sequence s_run;
        !restart_busy && !$past(restart_busy);
    endsequence
    sequence s_move;
        s_run ##0 $changed(setpoint_code);
    endsequence
    a_force_pin: assert property (mode_sync_pin [*5] |-> fixed_freq_force)
        else $error("forced pwm ignores mode pin");
    a_step_one: assert property (s_move |-> setpoint_code == 8'($past(setpoint_code) + 8'h01) ||
        setpoint_code == 8'($past(setpoint_code) - 8'h01))
        else $error("ramp moved more than one code");
    a_step_gap: assert property (s_move |=> (restart_busy || $stable(setpoint_code)) [*8])
        else $error("ramp steps too close");
    a_hold_idle: assert property (s_run ##0 !$past(setpoint_slewing) |-> $stable(setpoint_code))
        else $error("code moved while not slewing");
    a_uv_value: assert property (s_run |-> vout_target_uv ==
        rsc_pkg::BASE_UV + 21'($past(setpoint_code)) * step_of($past(range_select)))
        else $error("target voltage wrong");
    a_switch_off: assert property (restart_busy |-> !switching_active)
        else $error("switching during startup wait");
    a_busy_span: assert property ($fell(restart_busy) |-> busy_q >= RESTART_CYC - 1 && busy_q <= RESTART_CYC + 6)
        else $error("startup wait length wrong");
    a_supply_drop: assert property (!supply_ok [*5] |-> restart_busy)
        else $error("low supply did not restart");
    a_startup_code: assert property ($fell(restart_busy) ##0 $stable(startup_select_pin) |->
        setpoint_code == code_of(startup_select_pin))
        else $error("startup code wrong");
endmodule
bind rsc_regs rsc_regs_asserts #(.RESTART_CYC(RESTART_CYC)) u_rsc_regs_asserts (.mclk(mclk), .sys_rst(sys_rst),
    .mode_sync_pin(mode_sync_pin), .supply_ok(supply_ok), .startup_select_pin(startup_select_pin),
    .setpoint_code(setpoint_code), .vout_target_uv(vout_target_uv), .range_select(range_select),
    .switching_active(switching_active), .fixed_freq_force(fixed_freq_force),
    .setpoint_slewing(setpoint_slewing), .restart_busy(restart_busy));

// ### verification/rsc_regs_bench.sv
`timescale 1ns/1ns
module rsc_regs_bench;
    localparam logic [47:0] DFLT = 48'h78280a000000;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic supply_ok = 1'b1;
    logic mode_sync_pin = 1'b0;
    logic [1:0] startup_select_pin = 2'h2;
    logic [5:0] event_in = 6'h00;
    logic scl, sda_low, sda_o, sda_oe, sda_w;
    logic [7:0] setpoint_code;
    logic [20:0] vout_target_uv;
    logic [1:0] range_select;
    logic spread_clock_enable, switching_active, fixed_freq_force, output_drain_enable, fault_retry_enable;
    logic setpoint_slewing, restart_busy;
    logic [4:0] bits;
    int fails = 0;
    int checked = 0;
    int cycles = 0;
    int n;
    always #5 mclk = ~mclk;
    assign sda_w = !(sda_oe && !sda_o) && !sda_low;
    assign bits = {spread_clock_enable, switching_active, fixed_freq_force, output_drain_enable, fault_retry_enable};
    rsc_regs #(.RESTART_CYC(60)) u_rsc_regs (.mclk(mclk), .sys_rst(sys_rst), .scl_i(scl), .sda_i(sda_w),
        .sda_o(sda_o), .sda_oe(sda_oe), .startup_select_pin(startup_select_pin), .mode_sync_pin(mode_sync_pin),
        .supply_ok(supply_ok), .event_in(event_in), .setpoint_code(setpoint_code), .vout_target_uv(vout_target_uv),
        .range_select(range_select), .spread_clock_enable(spread_clock_enable), .switching_active(switching_active),
        .fixed_freq_force(fixed_freq_force), .output_drain_enable(output_drain_enable),
        .fault_retry_enable(fault_retry_enable), .setpoint_slewing(setpoint_slewing), .restart_busy(restart_busy));
    rsc_ctrl_model u_rsc_ctrl_model (.mclk(mclk), .sda_w(sda_w), .scl(scl), .sda_low(sda_low));
    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
        #1;
    endtask
    task automatic conclude();
        $display("counts: %0d checked, %0d failed", checked, fails);
        if (fails == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk_val(input logic [20:0] got, input logic [20:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] v;
        u_rsc_ctrl_model.read_reg(a, v);
        checked++;
        if (v !== exp) begin
            fails++;
            $display("BAD t=%0t reg %0h got %0h exp %0h", $time, a, v, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        u_rsc_ctrl_model.write_reg(a, d);
        tick(3);
    endtask
    task automatic wait_on(input int lim, output int k);
        k = 0;
        while ((restart_busy !== 1'b0 || setpoint_slewing !== 1'b0) && k < lim) begin
            tick(1);
            k++;
        end
    endtask
    function automatic int ivl(input int s);
        return (s == 0 ? rsc_pkg::RAMP_CYC_0 : s == 1 ? rsc_pkg::RAMP_CYC_1 : s == 2 ? rsc_pkg::RAMP_CYC_2
            : rsc_pkg::RAMP_CYC_3) << 2;
    endfunction
    function automatic logic [20:0] stp(input int r);
        return r == 0 ? rsc_pkg::STEP_UV_R1 : r == 1 ? rsc_pkg::STEP_UV_R2 : rsc_pkg::STEP_UV_R3;
    endfunction
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 60000) begin
            fails++;
            $display("BAD t=%0t timeout", $time);
            conclude();
        end
    end
    initial begin
        tick(5);
        sys_rst = 1'b0;
        wait_on(300, n);
        for (int i = 0; i < 6; i++) chk_reg(8'(i), DFLT[47-8*i -: 8]);
        chk_val(21'(bits), 21'h0a, "fields");
        chk_val(vout_target_uv, rsc_pkg::BASE_UV + 21'(8'h78) * rsc_pkg::STEP_UV_R3, "uv");
        $display("test defaults done");
        wr(8'h01, 8'h57);
        chk_val(21'(bits), 21'h15, "fields");
        chk_reg(8'h01, 8'h57);
        wr(8'h01, 8'h28);
        mode_sync_pin = 1'b1;
        tick(5);
        chk_val(21'(fixed_freq_force), 21'h1, "pin force");
        mode_sync_pin = 1'b0;
        tick(5);
        chk_val(21'(bits), 21'h0a, "fields");
        wr(8'h04, 8'hff);
        chk_reg(8'h05, 8'h00);
        $display("test fields done");
        for (int s = 0; s < 4; s++) begin
            wr(8'h01, 8'h28 | 8'(s));
            wr(8'h00, 8'h79 - 8'(s & 1));
            chk_val(21'(setpoint_slewing), 21'h1, "slewing");
            wait_on(1200, n);
            chk_val(21'(n <= ivl(s) && n + 24 >= ivl(s)), 21'h1, "interval");
            chk_val(21'(setpoint_code), 21'(8'h79 - 8'(s & 1)), "code");
        end
        wr(8'h01, 8'h28);
        wr(8'h00, 8'hf0);
        wait_on(7000, n);
        chk_val(21'(setpoint_code), 21'hf0, "code");
        $display("test ramp done");
        for (int r = 3; r >= 0; r--) begin
            wr(8'h02, {4'h0, 2'(r), 2'h2});
            chk_val(21'(range_select), 21'(r), "range");
            chk_val(vout_target_uv, rsc_pkg::BASE_UV + 21'(8'hf0) * stp(r), "uv");
            wr(8'h00, 8'hf0);
        end
        event_in = 6'h21;
        tick(4);
        event_in = 6'h00;
        chk_reg(8'h04, 8'h21);
        chk_reg(8'h04, 8'h00);
        $display("test range done");
        startup_select_pin = 2'h3;
        wr(8'h01, 8'h80);
        chk_val(21'(restart_busy), 21'h1, "restart");
        wait_on(300, n);
        chk_reg(8'h00, 8'ha0);
        chk_reg(8'h01, 8'h28);
        chk_reg(8'h02, 8'h0a);
        wr(8'h02, 8'h06);
        startup_select_pin = 2'h0;
        supply_ok = 1'b0;
        tick(6);
        chk_val(21'(restart_busy), 21'h1, "supply");
        supply_ok = 1'b1;
        tick(4);
        wait_on(300, n);
        chk_reg(8'h02, 8'h0a);
        chk_reg(8'h00, 8'h50);
        chk_val(21'(u_rsc_ctrl_model.misses), 21'h0, "acks");
        $display("test reset done");
        conclude();
    end
endmodule
